// file: rail_seq_pkg.sv
// Purpose: shared constants and types for the output rail sequencer
// Assumes: 125 MHz system clock, millisecond timing granularity
// Notes:   voltages are carried in millivolts, times in milliseconds
package rail_seq_pkg;

  // clock rate and the millisecond tick derived from it
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned CYC_PER_MS_DFLT = CLK_HZ / MS_PER_S;

  // start-up timing, in milliseconds
  localparam logic [7:0] INIT_MS    = 8'h40;  // 64 ms, inside 60..70 ms
  localparam logic [7:0] MIN_TON_MS = 8'h02;  // internal init after enable

  // setpoint limits, in millivolts
  localparam logic [11:0] VCMD_MIN_MV  = 12'h258;  // 0.60 V
  localparam logic [11:0] VCMD_MAX_MV  = 12'h9C4;  // 2.50 V
  localparam logic [11:0] VCEIL_MV     = 12'hABE;  // 2.75 V
  localparam logic [11:0] VSTRAP_DF_MV = 12'h3E8;  // 1.00 V, unused codes

  // power-good window default and ceiling default scale
  localparam logic [7:0] PG_PCT_RST    = 8'h0A;    // 10 %
  localparam logic [7:0] PG_DELAY_RST  = 8'h00;
  localparam logic [7:0] CEIL_PCT      = 8'h6E;    // 110 %
  localparam logic [7:0] PCT_FULL      = 8'h64;    // 100 %

  // sequencer states, gray coded along the on/off path
  typedef enum logic [2:0] {
    ST_INIT     = 3'h0,
    ST_OFF      = 3'h1,
    ST_TON_DLY  = 3'h3,
    ST_RAMP_UP  = 3'h2,
    ST_ON       = 3'h6,
    ST_TOFF_DLY = 3'h7,
    ST_RAMP_DN  = 3'h5
  } seq_state_e;

  // host configuration image, taken on a load strobe
  typedef struct packed {
    logic [7:0]  ton_delay_ms;
    logic [7:0]  ton_rise_ms;
    logic [7:0]  toff_delay_ms;
    logic [7:0]  toff_fall_ms;
    logic        immediate_off;
    logic [11:0] vout_cmd_mv;
    logic [11:0] vout_max_mv;
    logic [7:0]  rate_mv_per_ms;  // 0 jumps at once
    logic [7:0]  pg_window_pct;
    logic [7:0]  pg_delay_ms;
  } cfg_s;

endpackage

// file: output_rail_sequencer.sv
// Purpose: turn-on/turn-off sequencing, setpoint and power-good of a rail
// Assumes: strap pins carry already digitised resistor codes and are static
// Notes:   host settings arrive as one image with a load strobe
//
// Notes on behaviour
// - after power-up spend about 64 ms loading settings before commands and enable.
// - turn-on delay starts at enable; ramp begins only after it expires.
// - delay and rise are programmable; zero delay still waits about 2 ms.
// - zero rise time applies the full target setpoint at once.
// - turn-off delay and fall time are programmable separately from turn-on.
// - immediate off drops the power stage when the off delay expires.
// - sharing mode holds adaptive gain off during ramp, restores it at power-good.
// - sharing mode allows only immediate off.
// - soft-start strap code picks a delay of 5/10/20 ms and ramp 2/5/10 ms.
// - output-ok only when output is inside the window and no fault.
// - output-ok window defaults to 10 percent, host may change it.
// - output-ok waits a programmable hold time after conditions are met.
// - voltage strap code picks 0.60 to 2.50 V; three codes need a build option.
// - host setpoint 0.6 to 2.5 V, changed live at the programmed rate.
// - ceiling defaults to 110 percent of strap setpoint, host may set to 2.75 V.
// - address stays on straps; every other setting is host programmable.
`timescale 1ns/1ps
module output_rail_sequencer #(
  parameter int unsigned CYC_PER_MS  = rail_seq_pkg::CYC_PER_MS_DFLT,
  parameter bit          EXTRA_CODES = 1'b0  // optional strap setpoints
) (
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic               enable_pin,
  input  wire logic [4:0]         voltage_strap_pin,
  input  wire logic [3:0]         softstart_strap_pin,
  input  wire logic               current_share,
  input  wire logic               host_load,
  input  wire rail_seq_pkg::cfg_s host_cfg,
  input  wire logic               fault,
  input  wire logic [11:0]        vout_sense_mv,
  output logic                    cmd_ready,
  output logic                    stage_on,
  output logic [11:0]             setpoint_mv,
  output logic [11:0]             vout_ceiling_mv,
  output logic                    output_ok_flag,
  output logic                    adaptive_loop_gain
);
  import rail_seq_pkg::*;

  // strap setpoint lookup; a code outside the table falls back to 1.00 V
  function automatic logic [11:0] voltage_strap_pin_mv(input logic [4:0] code,
                                          input bit extra);
    logic [11:0] v;
    v = VSTRAP_DF_MV;
    case (code)
      5'h00: v = 12'h258;
      5'h01: v = 12'h28A;
      5'h02: v = 12'h2BC;
      5'h03: v = extra ? 12'h2D0 : VSTRAP_DF_MV;
      5'h04: v = 12'h2EE;
      5'h05: v = 12'h320;
      5'h06: v = 12'h352;
      5'h07: v = extra ? 12'h370 : VSTRAP_DF_MV;
      5'h08: v = 12'h384;
      5'h09: v = extra ? 12'h398 : VSTRAP_DF_MV;
      5'h0A: v = 12'h3B6;
      5'h0B: v = 12'h3E8;
      5'h0C: v = 12'h41A;
      5'h0D: v = 12'h44C;
      5'h0E: v = 12'h47E;
      5'h0F: v = 12'h4B0;
      5'h10: v = 12'h4E2;
      5'h11: v = 12'h514;
      5'h12: v = 12'h578;
      5'h13: v = 12'h5DC;
      5'h14: v = 12'h640;
      5'h15: v = 12'h6A4;
      5'h16: v = 12'h708;
      5'h17: v = 12'h76C;
      5'h18: v = 12'h7D0;
      5'h19: v = 12'h834;
      5'h1A: v = 12'h898;
      5'h1B: v = 12'h8FC;
      5'h1C: v = 12'h9C4;
      default: v = VSTRAP_DF_MV;
    endcase
    return v;
  endfunction

  // soft-start strap: both halves of the code range repeat the same pairs
  function automatic logic [15:0] ss_strap(input logic [2:0] code);
    logic [15:0] dr;  // {delay_ms, ramp_ms}
    case (code)
      3'h0:    dr = {8'h05, 8'h02};
      3'h1:    dr = {8'h0A, 8'h02};
      3'h2:    dr = {8'h05, 8'h05};
      3'h3:    dr = {8'h0A, 8'h05};
      3'h4:    dr = {8'h14, 8'h05};
      3'h5:    dr = {8'h05, 8'h0A};
      3'h6:    dr = {8'h0A, 8'h0A};
      default: dr = {8'h14, 8'h0A};
    endcase
    return dr;
  endfunction

  // clamp a value into [lo, hi]
  function automatic logic [11:0] clamp_mv(input logic [11:0] v,
                                           input logic [11:0] lo,
                                           input logic [11:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  seq_state_e  state_reg, state_next;
  logic        en_s1, en_s2, en_s3, en_reg;
  logic [16:0] div_reg;
  logic        tick;
  logic [7:0]  timer_reg, timer_load;
  logic        entering;
  cfg_s        cfg_reg;
  logic [11:0] target_mv;
  logic [25:0] acc_reg, ramp_thr, acc_sum;
  logic [11:0] span_reg, ramp_goal;
  logic [7:0]  pg_cnt_reg;
  logic [23:0] err_scaled, win_scaled;
  logic [11:0] err_mv;
  logic        pg_cond, immed_off;

  // enable pin: three-stage synchroniser, accept a level once 2nd and 3rd agree
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      en_s1  <= 1'b0;
      en_s2  <= 1'b0;
      en_s3  <= 1'b0;
      en_reg <= 1'b0;
    end else begin
      en_s1 <= enable_pin;
      en_s2 <= en_s1;
      en_s3 <= en_s2;
      if (en_s2 == en_s3) begin
        en_reg <= en_s3;
      end
    end
  end

  assign entering = (state_next != state_reg);
  assign tick     = (div_reg == 17'(CYC_PER_MS - 1));

  // millisecond divider; restarts on every state change so delays are exact
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 17'h00000;
    end else if (entering || tick) begin
      div_reg <= 17'h00000;
    end else begin
      div_reg <= div_reg + 17'h00001;
    end
  end

  assign immed_off = cfg_reg.immediate_off || current_share;
  assign target_mv = (cfg_reg.vout_cmd_mv > cfg_reg.vout_max_mv) ?
                     cfg_reg.vout_max_mv : cfg_reg.vout_cmd_mv;

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    timer_load = 8'h00;
    case (state_reg)
      ST_INIT: begin
        if (timer_reg == 8'h00) begin
          state_next = ST_OFF;
        end
      end
      ST_OFF: begin
        if (en_reg) begin
          state_next = ST_TON_DLY;
          timer_load = (cfg_reg.ton_delay_ms < MIN_TON_MS) ?
                       MIN_TON_MS : cfg_reg.ton_delay_ms;
        end
      end
      ST_TON_DLY: begin
        if (!en_reg) begin
          state_next = ST_OFF;  // request withdrawn before the ramp began
        end else if (timer_reg == 8'h00) begin
          state_next = ST_RAMP_UP;
        end
      end
      ST_RAMP_UP: begin
        if (!en_reg) begin
          state_next = ST_TOFF_DLY;
          timer_load = cfg_reg.toff_delay_ms;
        end else if (setpoint_mv == target_mv) begin
          state_next = ST_ON;
        end
      end
      ST_ON: begin
        if (!en_reg) begin
          state_next = ST_TOFF_DLY;
          timer_load = cfg_reg.toff_delay_ms;
        end
      end
      ST_TOFF_DLY: begin
        if (timer_reg == 8'h00) begin
          state_next = immed_off ? ST_OFF : ST_RAMP_DN;
        end
      end
      ST_RAMP_DN: begin
        if (setpoint_mv == 12'h000) begin
          state_next = ST_OFF;
        end
      end
      default: state_next = ST_INIT;
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // delay timer in milliseconds, reloaded whenever the state changes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timer_reg <= INIT_MS;
    end else if (entering) begin
      timer_reg <= timer_load;
    end else if (tick && timer_reg != 8'h00) begin
      timer_reg <= timer_reg - 8'h01;
    end
  end

  // working configuration: straps at init end, host image afterwards
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg                <= '0;
      cfg_reg.pg_window_pct  <= PG_PCT_RST;
      cfg_reg.pg_delay_ms    <= PG_DELAY_RST;
      cfg_reg.vout_cmd_mv    <= VSTRAP_DF_MV;
      cfg_reg.vout_max_mv    <= VCEIL_MV;
    end else if (state_reg == ST_INIT) begin
      if (state_next == ST_OFF) begin
        {cfg_reg.ton_delay_ms, cfg_reg.ton_rise_ms} <=
          ss_strap(softstart_strap_pin[2:0]);
        {cfg_reg.toff_delay_ms, cfg_reg.toff_fall_ms} <=
          ss_strap(softstart_strap_pin[2:0]);
        cfg_reg.vout_cmd_mv <= voltage_strap_pin_mv(voltage_strap_pin, EXTRA_CODES);
        cfg_reg.vout_max_mv <= clamp_mv(12'(
          (24'(voltage_strap_pin_mv(voltage_strap_pin, EXTRA_CODES)) * 24'(CEIL_PCT))
          / 24'(PCT_FULL)), 12'h000, VCEIL_MV);
      end
    end else if (host_load) begin
      cfg_reg <= host_cfg;
      cfg_reg.vout_cmd_mv <= clamp_mv(host_cfg.vout_cmd_mv,
                                      VCMD_MIN_MV, VCMD_MAX_MV);
      cfg_reg.vout_max_mv <= clamp_mv(host_cfg.vout_max_mv,
                                      12'h000, VCEIL_MV);
    end
  end

  assign ramp_thr  = (state_reg == ST_RAMP_DN) ?
                     26'(cfg_reg.toff_fall_ms * CYC_PER_MS) :
                     26'(cfg_reg.ton_rise_ms * CYC_PER_MS);
  assign ramp_goal = (state_reg == ST_RAMP_DN) ? 12'h000 : target_mv;
  assign acc_sum   = acc_reg + 26'(span_reg);

  // ramp span captured at entry: full target going up, present level down
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      span_reg <= 12'h000;
    end else if (entering) begin
      span_reg <= (state_next == ST_RAMP_DN) ? setpoint_mv : target_mv;
    end
  end

  // setpoint: one millivolt per threshold crossing gives a linear ramp;
  // with the default 125000 cycles per millisecond the span is below one millisecond of cycles, so at most one step per clock
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      setpoint_mv <= 12'h000;
      acc_reg     <= 26'h0000000;
    end else if (entering) begin
      acc_reg <= 26'h0000000;
      if (state_next == ST_OFF) begin
        setpoint_mv <= 12'h000;
      end
    end else begin
      case (state_reg)
        ST_RAMP_UP, ST_RAMP_DN: begin
          if (ramp_thr == 26'h0000000) begin
            setpoint_mv <= ramp_goal;
          end else if (acc_sum >= ramp_thr) begin
            acc_reg <= acc_sum - ramp_thr;
            if (setpoint_mv < ramp_goal) begin
              setpoint_mv <= setpoint_mv + 12'h001;
            end else if (setpoint_mv > ramp_goal) begin
              setpoint_mv <= setpoint_mv - 12'h001;
            end
          end else begin
            acc_reg <= acc_sum;
          end
        end
        ST_ON: begin
          if (cfg_reg.rate_mv_per_ms == 8'h00) begin
            setpoint_mv <= target_mv;
          end else if (tick && setpoint_mv < target_mv) begin
            setpoint_mv <= (target_mv - setpoint_mv >
                            12'(cfg_reg.rate_mv_per_ms)) ?
                           setpoint_mv + 12'(cfg_reg.rate_mv_per_ms) :
                           target_mv;
          end else if (tick && setpoint_mv > target_mv) begin
            setpoint_mv <= (setpoint_mv - target_mv >
                            12'(cfg_reg.rate_mv_per_ms)) ?
                           setpoint_mv - 12'(cfg_reg.rate_mv_per_ms) :
                           target_mv;
          end
        end
        default: setpoint_mv <= setpoint_mv;
      endcase
    end
  end

  // power stage runs from ramp start until the sequence returns to off
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage_on <= 1'b0;
    end else if (entering && state_next == ST_RAMP_UP) begin
      stage_on <= 1'b1;
    end else if (entering && state_next == ST_OFF) begin
      stage_on <= 1'b0;
    end
  end

  // commands and enable are honoured only once init has finished
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ready       <= 1'b0;
      vout_ceiling_mv <= 12'h000;
    end else begin
      cmd_ready       <= (state_reg != ST_INIT);
      vout_ceiling_mv <= cfg_reg.vout_max_mv;
    end
  end

  // window test: |sense - target| * 100 <= pct * target
  assign err_mv     = (vout_sense_mv > target_mv) ?
                      vout_sense_mv - target_mv : target_mv - vout_sense_mv;
  assign err_scaled = 24'(err_mv) * 24'(PCT_FULL);
  assign win_scaled = 24'(cfg_reg.pg_window_pct) * 24'(target_mv);
  assign pg_cond    = (state_reg == ST_ON) && !fault &&
                      (setpoint_mv == target_mv) && (err_scaled <= win_scaled);

  // output-ok drops at once when a condition fails; rises after the hold
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pg_cnt_reg     <= 8'h00;
      output_ok_flag <= 1'b0;
    end else if (!pg_cond) begin
      pg_cnt_reg     <= 8'h00;
      output_ok_flag <= 1'b0;
    end else if (pg_cnt_reg >= cfg_reg.pg_delay_ms) begin
      output_ok_flag <= 1'b1;
    end else if (tick) begin
      pg_cnt_reg <= pg_cnt_reg + 8'h01;
    end
  end

  // adaptive gain: on once init ends when alone; in sharing mode it waits for output-ok
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      adaptive_loop_gain <= 1'b0;
    end else if (!current_share) begin
      adaptive_loop_gain <= (state_reg != ST_INIT);
    end else if (entering && state_next == ST_TON_DLY) begin
      adaptive_loop_gain <= 1'b0;
    end else if (output_ok_flag) begin
      adaptive_loop_gain <= 1'b1;
    end
  end

endmodule

// file: rail_seq_monitor.sv
// Purpose: port-level checks on the output rail sequencer
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   window check trusts host loads made while cmd_ready is high
`timescale 1ns/1ps
module rail_seq_monitor #(
  parameter int unsigned CYC_PER_MS = 20
) (
  input wire logic               clock,
  input wire logic               reset_n,
  input wire logic               enable_pin,
  input wire logic [4:0]         voltage_strap_pin,
  input wire logic [3:0]         softstart_strap_pin,
  input wire logic               current_share,
  input wire logic               host_load,
  input wire rail_seq_pkg::cfg_s host_cfg,
  input wire logic               fault,
  input wire logic [11:0]        vout_sense_mv,
  input wire logic               cmd_ready,
  input wire logic               stage_on,
  input wire logic [11:0]        setpoint_mv,
  input wire logic [11:0]        vout_ceiling_mv,
  input wire logic               output_ok_flag,
  input wire logic               adaptive_loop_gain
);
  import rail_seq_pkg::*;
  int unsigned init_cnt;
  int unsigned en_cnt;
  int unsigned dis_cnt;
  logic [7:0]  pct_reg;
  int          diff;
  logic        in_win;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // spans of start-up, enable high and enable low, in cycles
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      init_cnt <= 0;
      en_cnt   <= 0;
      dis_cnt  <= 0;
    end else begin
      init_cnt <= cmd_ready ? init_cnt : init_cnt + 1;
      en_cnt   <= enable_pin ? en_cnt + 1 : 0;
      dis_cnt  <= enable_pin ? 0 : dis_cnt + 1;
    end
  end
  // shadow of the window width, taken with each accepted load
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pct_reg <= PG_PCT_RST;
    end else if (host_load && cmd_ready) begin
      pct_reg <= host_cfg.pg_window_pct;
    end
  end
  // sensed level against the reference, widened to avoid overflow
  always_comb begin
    diff   = int'(vout_sense_mv) - int'(setpoint_mv);
    diff   = (diff < 0) ? -diff : diff;
    in_win = diff * 100 <= int'(pct_reg) * int'(setpoint_mv);
  end
  property p_init_time;
    $rose(cmd_ready) |->
      init_cnt >= 64 * CYC_PER_MS && init_cnt <= 70 * CYC_PER_MS;
  endproperty
  a_init_time: assert property (p_init_time)
    else $error("ready outside start-up span");
  property p_ready_first; stage_on |-> cmd_ready; endproperty
  a_ready_first: assert property (p_ready_first)
    else $error("stage on before ready");
  property p_ton_delay; $rose(stage_on) |-> en_cnt >= 2 * CYC_PER_MS; endproperty
  a_ton_delay: assert property (p_ton_delay)
    else $error("ramp before turn-on delay");
  property p_toff_delay; $fell(stage_on) |-> dis_cnt >= CYC_PER_MS; endproperty
  a_toff_delay: assert property (p_toff_delay)
    else $error("stage off before turn-off delay");
  property p_fault_block; fault |=> !output_ok_flag; endproperty
  a_fault_block: assert property (p_fault_block)
    else $error("ok flag during fault");
  property p_window; output_ok_flag |-> $past(in_win); endproperty
  a_window: assert property (p_window)
    else $error("ok flag outside window");
  property p_gain_off; current_share && $rose(stage_on) |-> !adaptive_loop_gain;
  endproperty
  a_gain_off: assert property (p_gain_off)
    else $error("adaptive gain on during shared ramp");
  property p_gain_on;
    current_share && $rose(adaptive_loop_gain) |-> $past(output_ok_flag);
  endproperty
  a_gain_on: assert property (p_gain_on)
    else $error("adaptive gain back before ok flag");
  property p_share_imm;
    current_share && $fell(stage_on) |-> $past(setpoint_mv) != 12'h000;
  endproperty
  a_share_imm: assert property (p_share_imm)
    else $error("shared rail ramped down");
  property p_set_max; setpoint_mv <= VCMD_MAX_MV; endproperty
  a_set_max: assert property (p_set_max)
    else $error("setpoint above range");
  property p_ceil_max; vout_ceiling_mv <= VCEIL_MV; endproperty
  a_ceil_max: assert property (p_ceil_max)
    else $error("ceiling above limit");
  c_ramp: cover property ($rose(stage_on));
  c_ok: cover property ($rose(output_ok_flag));
  c_share_off: cover property (current_share && $fell(stage_on));
endmodule
bind output_rail_sequencer rail_seq_monitor #(.CYC_PER_MS(CYC_PER_MS))
  i_rail_seq_monitor (.clock(clock), .reset_n(reset_n),
  .enable_pin(enable_pin), .voltage_strap_pin(voltage_strap_pin),
  .softstart_strap_pin(softstart_strap_pin), .current_share(current_share),
  .host_load(host_load), .host_cfg(host_cfg), .fault(fault),
  .vout_sense_mv(vout_sense_mv), .cmd_ready(cmd_ready), .stage_on(stage_on),
  .setpoint_mv(setpoint_mv), .vout_ceiling_mv(vout_ceiling_mv),
  .output_ok_flag(output_ok_flag), .adaptive_loop_gain(adaptive_loop_gain));

// file: rail_load_model.sv
// Purpose: stand-in for the power stage, load and sense path
// Assumes: output settles on the reference one cycle later
// Notes:   offset_mv lets a test push the sensed level out of window
`timescale 1ns/1ps
module rail_load_model (
  input  wire logic        clock,
  input  wire logic        stage_on,
  input  wire logic [11:0] setpoint_mv,
  input  wire logic [11:0] offset_mv,
  output logic [11:0]      vout_sense_mv
);
  // a stopped stage discharges the rail, so no stale level is left
  always_ff @(posedge clock) begin
    vout_sense_mv <= stage_on ? setpoint_mv + offset_mv : 12'h000;
  end
endmodule

// file: output_rail_sequencer_tb.sv
// Purpose: self-checking bench for the output rail sequencer
// Assumes: one millisecond shortened to 600 cycles
// Notes:   straps pick 1.05 V and the 5 ms delay / 2 ms ramp code
`timescale 1ns/1ps
module output_rail_sequencer_tb;
  import rail_seq_pkg::*;
  localparam int CPM = 600;
  typedef struct packed {
    logic [11:0] cmd;
    logic [11:0] mx;
    logic [11:0] set;
    logic [11:0] ceil;
  } row_s;
  logic        clock = 1'b0;
  logic        reset_n;
  logic        enable_pin;
  logic [4:0]  voltage_strap_pin;
  logic [3:0]  softstart_strap_pin;
  logic        current_share;
  logic        host_load;
  cfg_s        host_cfg;
  cfg_s        c;
  logic        fault;
  logic [11:0] vout_sense_mv;
  logic [11:0] offset_mv;
  logic        cmd_ready;
  logic        stage_on;
  logic [11:0] setpoint_mv;
  logic [11:0] vout_ceiling_mv;
  logic        output_ok_flag;
  logic        adaptive_loop_gain;
  int          err_count = 0;
  int          tests_run = 0;
  int          n;
  // host setpoint and ceiling, clamped values beside them
  row_s        rows [4] = '{'{12'h7D0, 12'h5DC, 12'h5DC, 12'h5DC},
                            '{12'hBB8, 12'hABE, 12'h9C4, 12'hABE},
                            '{12'h190, 12'hBB8, 12'h258, 12'hABE},
                            '{12'h4B0, 12'hABE, 12'h4B0, 12'hABE}};

  output_rail_sequencer #(.CYC_PER_MS(CPM), .EXTRA_CODES(1'b0))
    i_output_rail_sequencer (.clock(clock), .reset_n(reset_n),
    .enable_pin(enable_pin), .voltage_strap_pin(voltage_strap_pin),
    .softstart_strap_pin(softstart_strap_pin), .current_share(current_share),
    .host_load(host_load), .host_cfg(host_cfg), .fault(fault),
    .vout_sense_mv(vout_sense_mv), .cmd_ready(cmd_ready), .stage_on(stage_on),
    .setpoint_mv(setpoint_mv), .vout_ceiling_mv(vout_ceiling_mv),
    .output_ok_flag(output_ok_flag), .adaptive_loop_gain(adaptive_loop_gain));
  rail_load_model i_rail_load_model (.clock(clock), .stage_on(stage_on),
    .setpoint_mv(setpoint_mv), .offset_mv(offset_mv),
    .vout_sense_mv(vout_sense_mv));

  // 125 MHz
  always #4 clock = ~clock;

  task end_sim();
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask
  task rng(input int v, input int lo, input int hi);
    check(32'(v >= lo && v <= hi), 32'h1);
  endtask
  // bounded wait sampled on the falling edge, away from launches
  task automatic wait_lvl(ref logic s, input logic v, input int lim,
                          output int k);
    k = 0;
    @(negedge clock);
    while (s !== v && k < lim) begin
      @(negedge clock);
      k++;
    end
  endtask
  task wait_set(input logic [11:0] v, output int k);
    k = 0;
    while (setpoint_mv !== v && k < 10 * CPM) begin
      @(negedge clock);
      k++;
    end
  endtask
  task load();
    @(posedge clock);
    host_cfg  <= c;
    host_load <= 1'b1;
    @(posedge clock);
    host_load <= 1'b0;
  endtask
  task en(input logic v);
    @(posedge clock);
    enable_pin <= v;
  endtask
  task pulse_fault();
    @(posedge clock);
    fault <= 1'b1;
    @(posedge clock);
    fault <= 1'b0;
  endtask

  // hang guard sized well above the planned sequence
  initial begin
    repeat (90000) @(posedge clock);
    err_count++;
    end_sim();
  end

  initial begin
    reset_n             = 1'b0;
    enable_pin          = 1'b0;
    voltage_strap_pin   = 5'h0C;
    softstart_strap_pin = 4'h0;
    current_share       = 1'b0;
    host_load           = 1'b0;
    c                   = '0;
    c.vout_cmd_mv       = 12'h41A;
    c.vout_max_mv       = 12'hABE;
    c.pg_window_pct     = PG_PCT_RST;
    c.toff_delay_ms     = 8'h02;
    host_cfg            = c;
    fault               = 1'b0;
    offset_mv           = 12'h000;
    repeat (20) @(posedge clock);
    @(negedge clock);
    check({cmd_ready, stage_on, output_ok_flag, adaptive_loop_gain}, 0);
    @(posedge clock);
    reset_n <= 1'b1;
    wait_lvl(cmd_ready, 1'b1, 80 * CPM, n);
    rng(n, 64 * CPM, 70 * CPM);
    repeat (3) @(negedge clock);
    check(vout_ceiling_mv, 12'h483);
    // strap timing: 5 ms delay, 2 ms ramp to 1.05 V
    // no sync clock
    en(1'b1);
    wait_lvl(stage_on, 1'b1, 10 * CPM, n);
    rng(n, 5 * CPM, 5 * CPM + 8);
    wait_set(12'h41A, n);
    rng(n, CPM, 2 * CPM + 4);
    wait_lvl(output_ok_flag, 1'b1, CPM, n);
    rng(n, 0, 4);
    pulse_fault();
    @(negedge clock);
    check(output_ok_flag, 1'b0);
    // live setpoint and ceiling changes, rate zero
    foreach (rows[i]) begin
      c.vout_cmd_mv = rows[i].cmd;
      c.vout_max_mv = rows[i].mx;
      load();
      repeat (4) @(negedge clock);
      check(setpoint_mv, rows[i].set);
      check(vout_ceiling_mv, rows[i].ceil);
    end
    // live change at 100 mV per ms: 1.2 V to 1.5 V in three steps
    c.rate_mv_per_ms = 8'h64;
    c.vout_cmd_mv    = 12'h5DC;
    load();
    wait_set(12'h5DC, n);
    rng(n, 2 * CPM, 3 * CPM + 4);
    c.rate_mv_per_ms = 8'h00;
    c.vout_cmd_mv    = 12'h4B0;
    load();
    // window around 1.2 V: 96 mV inside, 144 mV outside
    @(posedge clock);
    offset_mv <= 12'h060;
    repeat (8) @(negedge clock);
    check(output_ok_flag, 1'b1);
    @(posedge clock);
    offset_mv <= 12'h090;
    repeat (4) @(negedge clock);
    check(output_ok_flag, 1'b0);
    c.pg_window_pct = 8'h0F;
    load();
    wait_lvl(output_ok_flag, 1'b1, CPM, n);
    rng(n, 0, 6);
    @(posedge clock);
    offset_mv <= 12'h000;
    c.pg_window_pct = PG_PCT_RST;
    c.pg_delay_ms   = 8'h03;
    load();
    pulse_fault();
    wait_lvl(output_ok_flag, 1'b1, 10 * CPM, n);
    rng(n, 2 * CPM, 3 * CPM + 4);
    // soft stop: 2 ms delay then 3 ms fall
    c.pg_delay_ms  = 8'h00;
    c.toff_fall_ms = 8'h03;
    load();
    en(1'b0);
    wait_lvl(stage_on, 1'b0, 10 * CPM, n);
    rng(n, 3 * CPM, 5 * CPM + 8);
    // enable held low while configuring
    c.ton_delay_ms  = 8'h00;
    c.ton_rise_ms   = 8'h00;
    c.immediate_off = 1'b1;
    c.toff_delay_ms = 8'h01;
    load();
    en(1'b1);
    wait_lvl(stage_on, 1'b1, 10 * CPM, n);
    rng(n, 2 * CPM, 2 * CPM + 8);
    // the jump lands a cycle after stage_on
    @(negedge clock);
    check(setpoint_mv, 12'h4B0);
    en(1'b0);
    wait_lvl(stage_on, 1'b0, 10 * CPM, n);
    rng(n, CPM, CPM + 8);
    check(setpoint_mv, 12'h000);
    // enable dropped inside the turn-on delay never ramps
    c.ton_delay_ms = 8'h03;
    load();
    en(1'b1);
    repeat (CPM) @(posedge clock);
    enable_pin <= 1'b0;
    wait_lvl(stage_on, 1'b1, 4 * CPM, n);
    check(stage_on, 1'b0);
    // shared mode: gain held off in ramp, soft stop refused
    @(posedge clock);
    current_share   <= 1'b1;
    c.ton_delay_ms  = 8'h01;
    c.ton_rise_ms   = 8'h02;
    c.immediate_off = 1'b0;
    load();
    en(1'b1);
    wait_lvl(stage_on, 1'b1, 10 * CPM, n);
    check(adaptive_loop_gain, 1'b0);
    wait_lvl(output_ok_flag, 1'b1, 10 * CPM, n);
    repeat (2) @(negedge clock);
    check(adaptive_loop_gain, 1'b1);
    en(1'b0);
    wait_lvl(stage_on, 1'b0, 10 * CPM, n);
    rng(n, CPM, CPM + 8);
    // reset in mid-run drops everything at once
    en(1'b1);
    wait_lvl(stage_on, 1'b1, 10 * CPM, n);
    @(posedge clock);
    reset_n <= 1'b0;
    @(negedge clock);
    check({cmd_ready, stage_on, output_ok_flag, adaptive_loop_gain}, 0);
    end_sim();
  end
endmodule
